// *** rtl/spcc_ctrl.sv ***
// Shutdown and fault power-cycle controller of the power-state machine.
// Assumes synchronous inputs, a 25 MHz clock and single-cycle register strobes.
//
// Summary of operation
// - Any shutdown event moves the chip from active or hibernate to OFF.
// - Writing zero to system-on bit 15 of control register powers chip down.
// - GPIO power-off input active beyond 5ms causes shutdown; level set per pin.
// - Button held 10s causes shutdown, or 5s when hold-select bit 3 is set.
// - Control bit 1 picks button polarity: 0 high, 1 low; resets to 1.
// - Watchdog time-out shuts down only after 7 earlier faults.
// - Shutdown-requesting faults and thermal shutdown are shutdown events.
// - System-on flag is set to 1 during start-up.
// - Shutdown asserts host and memory resets, clears registers and system-on, enters OFF.
// - Switch and each regulator individually may request shutdown on a fault.
// - With restart enable bit 13 clear, a requesting fault goes through SHUT to OFF.
// - With restart enabled, a fault reruns start-up, up to 8 tries 200ms apart.
// - After 8 failed tries go to OFF and clear the attempt counter.
// - Control registers reset whenever OFF is entered.
// - Hibernate bit 5 set resets registers on hibernate exit; resets to 0.
// - Development mode field can suppress the register reset on entering OFF.
// - From OFF any valid start-up event restarts the chip.
// - Host reset output stays asserted throughout the OFF state.
`timescale 1ns/10ps
`include "spcc_defs.svh"

module spcc_ctrl
	import spcc_pkg::*;
#(
	parameter int NUM_SUPPLIES   = 11,
	parameter int GPIO_CYC       = `SPCC_GPIO_CYC,
	parameter int BTN_LONG_CYC   = `SPCC_BTN_LONG_CYC,
	parameter int BTN_SHORT_CYC  = `SPCC_BTN_SHORT_CYC,
	parameter int RETRY_CYC      = `SPCC_RETRY_CYC
) (
	// Clock, reset and enable.
	input  wire logic                    clock_i,
	input  wire logic                    reset_n_i,
	input  wire logic                    clk_en_i,
	// Register port.
	input  wire logic [7:0]              reg_addr_i,
	input  wire logic [15:0]             reg_wdata_i,
	input  wire logic                    reg_wr_i,
	input  wire logic                    reg_rd_i,
	output logic      [15:0]             reg_rdata_o,
	// Sensed pins and events.
	input  wire logic                    button_i,
	input  wire logic                    gpio_power_off_input_i,
	input  wire logic                    gpio_pin_config_i,
	input  wire logic                    watchdog_timeout_i,
	input  wire logic                    thermal_shutdown_i,
	input  wire logic [NUM_SUPPLIES-1:0] supply_fault_i,
	input  wire logic [NUM_SUPPLIES-1:0] supply_fault_shutdown_en_i,
	input  wire logic                    startup_event_i,
	input  wire logic                    startup_done_i,
	input  wire logic                    hibernate_req_i,
	input  wire logic                    wake_req_i,
	input  wire logic                    dev_mode_i,
	input  wire logic                    dev_keep_regs_in_off_i,
	// Reset and state outputs.
	output logic                         host_reset_n_o,
	output logic                         memory_reset_n_o,
	output logic                         reg_clear_o,
	output logic                         functions_en_o,
	output logic                         startup_run_o
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	localparam int CW = 28;

	spcc_state_t state_q, state_d;
	logic [15:0] ctrl1_q;
	logic [15:0] hib_q;
	logic [CW-1:0] gpio_cnt_q;
	logic [CW-1:0] btn_cnt_q;
	logic [CW-1:0] retry_cnt_q;
	logic [3:0] attempt_q;
	logic [3:0] fault_cnt_q;
	logic retry_wait_q;
	logic [15:0] rdata_q;
	logic [1:0] last_cause_q;

	// Saturating counter step shared by all timers.
	function automatic logic [CW-1:0] spcc_step(input logic [CW-1:0] c, input logic run);
		spcc_step = !run ? '0 : ((&c) ? c : c + 1'b1);
	endfunction

	// ****************************************************************
	// Event decode
	// ****************************************************************
	wire wr_ctrl1     = reg_wr_i && (reg_addr_i == `SPCC_ADDR_CTRL1);
	wire wr_hib       = reg_wr_i && (reg_addr_i == `SPCC_ADDR_HIB);
	wire powered      = state_q == SPCC_ACTIVE || state_q == SPCC_HIBER;
	wire sw_off       = wr_ctrl1 && !reg_wdata_i[`SPCC_BIT_SYSTEM_ON] && powered;
	// A GPIO configured active low is inverted here.
	wire gpio_active  = gpio_power_off_input_i ^ gpio_pin_config_i;
	wire gpio_off     = gpio_cnt_q >= CW'(GPIO_CYC);
	wire btn_active   = button_i ^ ctrl1_q[`SPCC_BIT_BTN_POL];
	wire [CW-1:0] btn_lim = ctrl1_q[`SPCC_BIT_HOLD_SEL] ? CW'(BTN_SHORT_CYC)
	                                                    : CW'(BTN_LONG_CYC);
	wire btn_off      = btn_cnt_q >= btn_lim;
	wire wdog_off     = watchdog_timeout_i && fault_cnt_q >= 4'(`SPCC_WDOG_FAULTS);
	// Each supply requests shutdown only when its own enable is set.
	wire fault_req    = |(supply_fault_i & supply_fault_shutdown_en_i);
	wire restart_en   = ctrl1_q[`SPCC_BIT_RESTART_EN];
	wire fault_live   = state_q == SPCC_STARTUP || powered;
	wire fault_retry  = fault_req && restart_en && fault_live &&
	                    attempt_q < 4'(`SPCC_MAX_ATTEMPTS - 1);
	wire fault_off    = fault_req && fault_live && !fault_retry;
	wire plain_off    = powered && (sw_off || gpio_off || btn_off || wdog_off ||
	                    thermal_shutdown_i);
	wire go_shut      = plain_off || fault_off;
	wire keep_regs    = dev_mode_i && dev_keep_regs_in_off_i;
	wire retry_fire   = retry_wait_q && retry_cnt_q >= CW'(RETRY_CYC - 1);
	wire hib_exit     = state_q == SPCC_HIBER && wake_req_i;
	wire clr_regs     = (state_d == SPCC_OFF && state_q != SPCC_OFF && !keep_regs) ||
	                    (hib_exit && hib_q[`SPCC_BIT_HIB_CLR]);

	// ****************************************************************
	// State machine
	// ****************************************************************
	// Next state; faults are checked ahead of the other causes.
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			SPCC_OFF: begin
				if (startup_event_i || retry_fire) begin
					state_d = SPCC_STARTUP;
				end
			end
			SPCC_STARTUP: begin
				if (fault_retry) begin
					state_d = SPCC_OFF;
				end else if (fault_off) begin
					state_d = SPCC_SHUT;
				end else if (startup_done_i) begin
					state_d = SPCC_ACTIVE;
				end
			end
			SPCC_ACTIVE: begin
				if (fault_retry) begin
					state_d = SPCC_OFF;
				end else if (go_shut) begin
					state_d = SPCC_SHUT;
				end else if (hibernate_req_i) begin
					state_d = SPCC_HIBER;
				end
			end
			SPCC_HIBER: begin
				if (fault_retry) begin
					state_d = SPCC_OFF;
				end else if (go_shut) begin
					state_d = SPCC_SHUT;
				end else if (wake_req_i) begin
					state_d = SPCC_ACTIVE;
				end
			end
			SPCC_SHUT: begin
				state_d = SPCC_OFF;
			end
			default: begin
				state_d = SPCC_OFF;
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			state_q <= SPCC_OFF;
		end else if (clk_en_i) begin
			state_q <= state_d;
		end
	end

	// ****************************************************************
	// Timers and counters
	// ****************************************************************
	// Pin timers only run while powered, so a held button cannot restart the count in OFF.
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			gpio_cnt_q  <= '0;
			btn_cnt_q   <= '0;
			retry_cnt_q <= '0;
		end else if (clk_en_i) begin
			gpio_cnt_q  <= spcc_step(gpio_cnt_q, gpio_active && powered);
			btn_cnt_q   <= spcc_step(btn_cnt_q, btn_active && powered);
			retry_cnt_q <= spcc_step(retry_cnt_q, retry_wait_q && !retry_fire);
		end
	end

	// Attempts and the fault tally for the watchdog decision.
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			attempt_q    <= '0;
			retry_wait_q <= 1'b0;
			fault_cnt_q  <= '0;
		end else if (clk_en_i) begin
			if (fault_retry) begin
				attempt_q    <= attempt_q + 1'b1;
				retry_wait_q <= 1'b1;
			end else if (fault_off || (state_q == SPCC_STARTUP && startup_done_i)) begin
				attempt_q    <= '0;
			end
			if (retry_fire || startup_event_i) begin
				retry_wait_q <= 1'b0;
			end
			if (fault_req && fault_live && fault_cnt_q != 4'hF) begin
				fault_cnt_q <= fault_cnt_q + 1'b1;
			end else if (state_q == SPCC_SHUT) begin
				fault_cnt_q <= '0;
			end
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	// Startup sets system-on; register clear wins over a write in the same cycle.
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			ctrl1_q <= `SPCC_CTRL1_RESET;
			hib_q   <= `SPCC_HIB_RESET;
		end else if (clk_en_i) begin
			if (clr_regs) begin
				ctrl1_q <= `SPCC_CTRL1_RESET;
				hib_q   <= `SPCC_HIB_RESET;
			end else begin
				if (wr_ctrl1) begin
					ctrl1_q <= reg_wdata_i;
				end
				if (wr_hib) begin
					hib_q <= reg_wdata_i;
				end
				// Leaving for OFF wins over start-up, so a retry never keeps system-on.
				if (state_d == SPCC_OFF || state_q == SPCC_SHUT) begin
					ctrl1_q[`SPCC_BIT_SYSTEM_ON] <= 1'b0;
				end else if (state_q == SPCC_STARTUP) begin
					ctrl1_q[`SPCC_BIT_SYSTEM_ON] <= 1'b1;
				end
			end
		end
	end

	// Cause of the last shutdown, kept for software.
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			last_cause_q <= 2'h0;
		end else if (clk_en_i && go_shut) begin
			last_cause_q <= fault_off ? 2'h2 : (sw_off ? 2'h1 : 2'h3);
		end
	end

	// Read data appear one cycle after the strobe; unmapped reads return zero.
	wire [15:0] rd_mux =
		(reg_addr_i == `SPCC_ADDR_CTRL1)  ? ctrl1_q :
		(reg_addr_i == `SPCC_ADDR_HIB)    ? hib_q :
		(reg_addr_i == `SPCC_ADDR_STATUS) ? {3'h0, state_q, attempt_q, fault_cnt_q} :
		(reg_addr_i == `SPCC_ADDR_EVENT)  ? {14'h0, last_cause_q} : 16'h0000;

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			rdata_q <= 16'h0000;
		end else if (clk_en_i) begin
			rdata_q <= reg_rd_i ? rd_mux : 16'h0000;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// Both resets are low except in active; hibernate keeps them low here for safety.
	assign host_reset_n_o   = state_q == SPCC_ACTIVE;
	assign memory_reset_n_o = state_q == SPCC_ACTIVE;
	assign reg_clear_o      = state_q == SPCC_SHUT || (state_q == SPCC_OFF && !keep_regs);
	assign functions_en_o   = powered;
	assign startup_run_o    = state_q == SPCC_STARTUP;
	assign reg_rdata_o      = rdata_q;

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_off_host_reset: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		state_q == SPCC_OFF |-> !host_reset_n_o) else $error("host reset released in off");
	a_shut_to_off: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		clk_en_i && state_q == SPCC_SHUT |=> state_q == SPCC_OFF) else $error("shut not off");
	a_sw_shutdown: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		clk_en_i && sw_off && !fault_retry |=> state_q == SPCC_SHUT) else $error("sw off lost");
	a_startup_sets_on: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		clk_en_i && state_q == SPCC_STARTUP && !clr_regs && state_d != SPCC_OFF |=> ctrl1_q[15])
		else $error("on unset");
	a_off_clears_on: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		$rose(state_q == SPCC_OFF) |-> !ctrl1_q[15]) else $error("system on in off");
	a_attempt_bound: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		attempt_q <= 4'h8) else $error("attempts above eight");
	a_no_restart_off: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		clk_en_i && fault_req && !restart_en && powered |=> state_q == SPCC_SHUT)
		else $error("fault without restart not shut");
	a_done_clears: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		clk_en_i && state_q == SPCC_STARTUP && startup_done_i && !fault_req |=> attempt_q == 0)
		else $error("attempts not cleared");
	a_wdog_early: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		clk_en_i && state_q == SPCC_ACTIVE && watchdog_timeout_i && fault_cnt_q < 4'h7 &&
		!fault_req && !sw_off && !gpio_off && !btn_off && !thermal_shutdown_i &&
		!hibernate_req_i |=> state_q == SPCC_ACTIVE) else $error("early watchdog off");

	// The memory reset follows the host reset throughout OFF.
	a_off_mem_reset: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		state_q == SPCC_OFF |-> !memory_reset_n_o) else $error("memory reset released in off");

	// A fault that is retried drops straight to OFF to wait out the retry gap.
	a_retry_to_off: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		clk_en_i && fault_retry |=> state_q == SPCC_OFF) else $error("retry not off");

	// Entering OFF without the development keep leaves the control register at reset.
	a_off_entry_clear: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		clk_en_i && state_d == SPCC_OFF && state_q != SPCC_OFF && !keep_regs
		|=> ctrl1_q == `SPCC_CTRL1_RESET) else $error("registers kept in off");

	// Leaving hibernate with the clear bit set resets the hibernate register too.
	a_hib_exit_clear: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		clk_en_i && hib_exit && hib_q[`SPCC_BIT_HIB_CLR] |=> hib_q == `SPCC_HIB_RESET)
		else $error("hibernate exit kept registers");

	// Thermal shutdown is a plain shutdown event while powered.
	a_thermal_shut: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		clk_en_i && powered && thermal_shutdown_i && !fault_retry |=> state_q == SPCC_SHUT)
		else $error("thermal event lost");

	// A GPIO held past its limit shuts the chip down.
	a_gpio_shut: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		clk_en_i && powered && gpio_off && !fault_retry |=> state_q == SPCC_SHUT)
		else $error("gpio power off lost");

	// Any start-up event in OFF begins start-up on the next edge.
	a_off_restart: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		clk_en_i && state_q == SPCC_OFF && startup_event_i |=> state_q == SPCC_STARTUP)
		else $error("start-up event ignored");

endmodule

// *** rtl/spcc_defs.svh ***
// Constants for the shutdown and power-cycle controller: offsets, field bits, resets, times.
// Assumes the includer works at a 25 MHz clock.
`ifndef SPCC_DEFS_SVH
`define SPCC_DEFS_SVH

// ****************************************************************
// Register offsets and fields
// ****************************************************************
`define SPCC_ADDR_CTRL1     8'h03
`define SPCC_ADDR_HIB       8'h05
`define SPCC_ADDR_STATUS    8'h40
`define SPCC_ADDR_EVENT     8'h41
`define SPCC_BIT_SYSTEM_ON  15
`define SPCC_BIT_RESTART_EN 13
`define SPCC_BIT_HOLD_SEL   3
`define SPCC_BIT_BTN_POL    1
`define SPCC_BIT_HIB_CLR    5
`define SPCC_CTRL1_RESET    16'h0002
`define SPCC_HIB_RESET      16'h0000

// ****************************************************************
// Times and derived cycle counts
// ****************************************************************
`define SPCC_CLK_HZ         25000000
`define SPCC_GPIO_MS        5
`define SPCC_BTN_LONG_S     10
`define SPCC_BTN_SHORT_S    5
`define SPCC_RETRY_MS       200
`define SPCC_GPIO_CYC       ((`SPCC_CLK_HZ / 1000) * `SPCC_GPIO_MS + 1)
`define SPCC_BTN_LONG_CYC   (`SPCC_CLK_HZ * `SPCC_BTN_LONG_S)
`define SPCC_BTN_SHORT_CYC  (`SPCC_CLK_HZ * `SPCC_BTN_SHORT_S)
`define SPCC_RETRY_CYC      ((`SPCC_CLK_HZ / 1000) * `SPCC_RETRY_MS)
`define SPCC_MAX_ATTEMPTS   8
`define SPCC_WDOG_FAULTS    7

`endif

// *** rtl/spcc_pkg.sv ***
// Types for the shutdown and power-cycle controller.
// Assumes the constants header is included by the design files.
package spcc_pkg;
	// Power states, one-hot.
	typedef enum logic [4:0] {
		SPCC_OFF     = 5'b00001,
		SPCC_STARTUP = 5'b00010,
		SPCC_ACTIVE  = 5'b00100,
		SPCC_HIBER   = 5'b01000,
		SPCC_SHUT    = 5'b10000
	} spcc_state_t;
endpackage

// *** tb/spcc_pin_model.sv ***
// Pin model for the controller's far side: the ON button and a power-off GPIO input.
// Assumes the bench calls press from just after a rising clock edge.
`timescale 1ns/10ps

module spcc_pin_model (
	// Clock and active levels.
	input  wire logic clock_i,
	input  wire logic btn_act_low_i,
	input  wire logic gpio_act_low_i,
	// Pin levels.
	output logic      button_o,
	output logic      gpio_o
);
	logic btn_on  = 1'h0;
	logic gpio_on = 1'h0;

	// Idle pins rest at their inactive level, as the board pulls them there.
	assign button_o = btn_on ^ btn_act_low_i;
	assign gpio_o   = gpio_on ^ gpio_act_low_i;

	// Hold one pin active for n cycles, then release it.
	task automatic press(input int n, input logic gpio);
		if (gpio) gpio_on <= 1'h1;
		else btn_on <= 1'h1;
		repeat (n) @(posedge clock_i);
		gpio_on <= 1'h0;
		btn_on  <= 1'h0;
	endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the shutdown and power-cycle controller.
// Assumes the constants header, the package and the design are compiled first.
`timescale 1ns/10ps
`include "spcc_defs.svh"

module testbench
	import spcc_pkg::*;
;
	// Shortened counts so that every hold and retry fits a short run.
	localparam int GPIO_CYC  = 5;
	localparam int BTN_LONG  = 20;
	localparam int BTN_SHORT = 10;
	localparam int RETRY_CYC = 8;
	localparam int NS        = 11;
	logic          clock_i     = 1'h0;
	logic          reset_n_i   = 1'h0;
	logic [7:0]    reg_addr_i  = 8'h00;
	logic [15:0]   reg_wdata_i = 16'h0000;
	logic          reg_wr_i    = 1'h0;
	logic          reg_rd_i    = 1'h0;
	logic [15:0]   reg_rdata_o;
	logic          button_i, gpio_i, host_rst_n, mem_rst_n, fn_en, run, clr;
	logic          btn_low = 1'h1, wdog = 1'h0, therm = 1'h0, st_ev = 1'h0, st_done = 1'h0;
	logic          hib_req = 1'h0, wake = 1'h0, dev = 1'h0, keep = 1'h0, seen = 1'h0;
	logic [NS-1:0] fault = '0, fault_en = '0;
	logic [31:0]   lfsr = 32'hB1E58C10;
	logic [31:0]   note;
	logic [31:0]   exp_q[$];
	int            miscompares = 0, cmp_count = 0, idx = 0;

	always #20 clock_i = ~clock_i;

	spcc_ctrl #(.GPIO_CYC(GPIO_CYC), .BTN_LONG_CYC(BTN_LONG), .BTN_SHORT_CYC(BTN_SHORT),
		.RETRY_CYC(RETRY_CYC)) dut (
		.clock_i(clock_i), .reset_n_i(reset_n_i), .clk_en_i(1'h1), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .button_i(button_i), .gpio_power_off_input_i(gpio_i),
		.gpio_pin_config_i(1'h1), .watchdog_timeout_i(wdog), .thermal_shutdown_i(therm),
		.supply_fault_i(fault), .supply_fault_shutdown_en_i(fault_en), .startup_event_i(st_ev),
		.startup_done_i(st_done), .hibernate_req_i(hib_req), .wake_req_i(wake), .dev_mode_i(dev),
		.dev_keep_regs_in_off_i(keep), .host_reset_n_o(host_rst_n), .memory_reset_n_o(mem_rst_n),
		.reg_clear_o(clr), .functions_en_o(fn_en), .startup_run_o(run));

	spcc_pin_model pins (.clock_i(clock_i), .btn_act_low_i(btn_low), .gpio_act_low_i(1'h1),
		.button_o(button_i), .gpio_o(gpio_i));

	// ****************************************************************
	// Checking helpers
	// ****************************************************************
	function automatic logic [31:0] next_rand(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Read data stand only in the cycle after the strobe, so take the oldest note then.
	always @(posedge clock_i) begin
		if (seen) begin
			note = exp_q.pop_front();
			cmp(reg_rdata_o & note[31:16], note[15:0]);
		end
		seen <= reg_rd_i;
	end

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'h1;
		@(posedge clock_i);
		reg_wr_i    <= 1'h0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'h1;
		exp_q.push_back({m, e & m});
		@(posedge clock_i);
		reg_rd_i   <= 1'h0;
	endtask

	task automatic st(input spcc_state_t s);
		rd(`SPCC_ADDR_STATUS, {3'h0, s, 8'h00}, 16'h1F00);
	endtask

	// One-cycle pulse on an event input picked by k.
	task automatic hit(input int k);
		@(posedge clock_i);
		case (k)
			0: wdog <= 1'h1;
			1: therm <= 1'h1;
			2: fault[idx] <= 1'h1;
			3: hib_req <= 1'h1;
			4: wake <= 1'h1;
			5: st_done <= 1'h1;
			default: st_ev <= 1'h1;
		endcase
		@(posedge clock_i);
		{wdog, therm, fault, hib_req, wake, st_done, st_ev} <= '0;
	endtask

	task automatic go_active();
		hit(6);
		rd(`SPCC_ADDR_CTRL1, 16'h8000, 16'h8000);
		hit(5);
		st(SPCC_ACTIVE);
	endtask

	task automatic expect_off(input logic [15:0] c1);
		repeat (3) @(posedge clock_i);
		cmp({15'h0, host_rst_n}, 16'h0000);
		cmp({14'h0, mem_rst_n, fn_en}, 16'h0000);
		cmp({15'h0, clr}, {15'h0, ~keep});
		st(SPCC_OFF);
		rd(`SPCC_ADDR_CTRL1, c1, 16'hA00A);
	endtask

	// Counts cycles from a fault to the next start-up; outputs are read once settled.
	task automatic restart_gap(input logic on);
		int c;
		c = 0;
		#1;
		while (run !== 1'h1 && c < RETRY_CYC + 6) begin
			@(posedge clock_i);
			#1;
			c++;
		end
		cmp({15'h0, run}, {15'h0, on});
		if (on) cmp(16'(c), 16'(RETRY_CYC));
	endtask

	task automatic conclude();
		if (miscompares == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial begin
		repeat (5) @(posedge clock_i);
		reset_n_i <= 1'h1;
		rd(`SPCC_ADDR_CTRL1, 16'h0002, 16'hA00A);
		rd(`SPCC_ADDR_HIB, 16'h0000, 16'h0020);
		st(SPCC_OFF);
		lfsr = next_rand(next_rand(lfsr));
		idx = lfsr[15:8] % NS;
		rd({1'h1, lfsr[6:0]}, 16'h0000, 16'hFFFF);
		go_active();
		fault_en <= ~(11'h001 << idx);
		hit(0);
		hit(2);
		st(SPCC_ACTIVE);
		wr(`SPCC_ADDR_CTRL1, 16'h0002);
		expect_off(16'h0002);
		rd(`SPCC_ADDR_EVENT, 16'h0001, 16'hFFFF);
		go_active();
		fault_en <= '1;
		hit(2);
		expect_off(16'h0002);
		rd(`SPCC_ADDR_EVENT, 16'h0002, 16'hFFFF);
		// Long hold with active-low polarity, then short hold with active-high.
		for (int k = 0; k < 2; k++) begin
			go_active();
			btn_low <= ~k[0];
			wr(`SPCC_ADDR_CTRL1, k[0] ? 16'h8008 : 16'h8002);
			pins.press(BTN_SHORT + 2, 1'h0);
			if (k == 0) begin
				st(SPCC_ACTIVE);
				pins.press(BTN_LONG + 2, 1'h0);
			end
			expect_off(16'h0002);
			btn_low <= 1'h1;
		end
		go_active();
		pins.press(GPIO_CYC - 1, 1'h1);
		st(SPCC_ACTIVE);
		pins.press(GPIO_CYC + 2, 1'h1);
		expect_off(16'h0002);
		go_active();
		wr(`SPCC_ADDR_HIB, 16'h0020);
		hit(3);
		st(SPCC_HIBER);
		hit(4);
		hit(5);
		rd(`SPCC_ADDR_HIB, 16'h0000, 16'h0020);
		hit(3);
		hit(1);
		expect_off(16'h0002);
		// Registers kept across OFF so the retry policy survives each restart.
		dev  <= 1'h1;
		keep <= 1'h1;
		go_active();
		wr(`SPCC_ADDR_CTRL1, 16'hA002);
		for (int n = 1; n <= 8; n++) begin
			hit(2);
			restart_gap(n < 8);
		end
		expect_off(16'h2002);
		rd(`SPCC_ADDR_STATUS, {3'h0, SPCC_OFF, 8'h00}, 16'h1FF0);
		hit(6);
		for (int n = 1; n < 8; n++) begin
			hit(2);
			restart_gap(1'h1);
		end
		hit(5);
		rd(`SPCC_ADDR_STATUS, {3'h0, SPCC_ACTIVE, 8'h00}, 16'h1FF0);
		hit(0);
		expect_off(16'h2002);
		repeat (3) @(posedge clock_i);
		conclude();
	end

	// A hang past about fifteen times the expected run length ends the run as a failure.
	initial begin
		#(40 * 6000);
		miscompares++;
		conclude();
	end
endmodule
